// File: src/spt_pkg.sv
package spt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_COUNT = 16'h0100;
  localparam logic [15:0] IDX_PERIOD = 16'h0102;
  localparam logic [15:0] IDX_CTRL = 16'h0104;
  localparam logic [15:0] IDX_FLAG = 16'h0106;
  localparam int ADDR_W = 12;

  // Control field positions
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_IDLE_BIT = 13;
  localparam int CTRL_GATE_BIT = 6;
  localparam int CTRL_PS_HI = 5;
  localparam int CTRL_PS_LO = 4;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int CTRL_CS_BIT = 1;
  localparam int FLAG_BIT = 0;

  // Reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [7:0] PS_ZERO = 8'h00;
  localparam logic [7:0] PS_ONE = 8'h01;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PS_LIM_1 = 8'h00;
  localparam logic [7:0] PS_LIM_8 = 8'h07;
  localparam logic [7:0] PS_LIM_64 = 8'h3F;
  localparam logic [7:0] PS_LIM_256 = 8'hFF;

  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_GATED,
    MODE_SYNC,
    MODE_ASYNC
  } spt_mode_e;

  typedef struct packed {
    logic count_enable;
    logic idle_stop_bit;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic external_sync_select;
    logic clock_source_select;
  } spt_ctrl_s;

  typedef struct packed {
    logic [15:0] count_value;
    logic [15:0] period_value;
    spt_ctrl_s ctrl;
    logic period_match_flag;
    logic [7:0] presc;
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    logic ack;
    logic [31:0] rdata;
    logic irq;
  } spt_state_s;
endpackage

// File: src/spt_timer.sv
// Functional notes
// - Timer mode counts cycles, wraps after period
// - Idle stops count when idle-stop set
// - Sync counter counts synchronised external rising edges
// - Async counter counts the same synchronised external rising edges
// - Async counter stops in Idle only if set
// - Gated mode counts cycles while gate high
// - Prescaler divides by 1, 8, 64, 256
// - Count write, enable clear, reset clear prescaler
// - Disabled timer leaves prescaler untouched except by count write
// - Control write never changes the count
// - Interrupt on period match and gate fall
// - Match sets sticky flag, software clears it
// - Sleep counting only in async external mode
`timescale 1ns/1ps
`default_nettype none
module spt_timer
  import spt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_clock_gate_pin,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic period_match_flag,
  output logic irq_request
);

  spt_state_s q;
  spt_state_s next_q;

  // Index to byte address
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx[ADDR_W-3:0], 2'b00};
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // Prescaler terminal count
  function automatic logic [7:0] ps_limit(input logic [1:0] sel);
    case (sel)
      2'b00: ps_limit = PS_LIM_1;
      2'b01: ps_limit = PS_LIM_8;
      2'b10: ps_limit = PS_LIM_64;
      default: ps_limit = PS_LIM_256;
    endcase
  endfunction

  // Operating mode from control fields
  function automatic spt_mode_e mode_of(input spt_ctrl_s c);
    if (!c.clock_source_select) begin
      mode_of = c.gate_accumulate_enable ? MODE_GATED : MODE_TIMER;
    end else begin
      mode_of = c.external_sync_select ? MODE_SYNC : MODE_ASYNC;
    end
  endfunction

  // Control register image
  function automatic logic [15:0] ctrl_word(input spt_ctrl_s c);
    ctrl_word = 16'h0000;
    ctrl_word[CTRL_ON_BIT] = c.count_enable;
    ctrl_word[CTRL_IDLE_BIT] = c.idle_stop_bit;
    ctrl_word[CTRL_GATE_BIT] = c.gate_accumulate_enable;
    ctrl_word[CTRL_PS_HI:CTRL_PS_LO] = c.prescale_select;
    ctrl_word[CTRL_SYNC_BIT] = c.external_sync_select;
    ctrl_word[CTRL_CS_BIT] = c.clock_source_select;
  endfunction

  spt_mode_e mode;
  logic req;
  logic acc;
  logic wr_count;
  logic wr_period;
  logic wr_ctrl;
  logic wr_flag;
  logic run;
  logic src_pulse;
  logic in_pulse;
  logic tick;
  logic at_period;
  logic ext_rise;
  logic gate_fall;
  logic match_set;
  logic [7:0] lim;
  logic [15:0] ctrl_new;

  // Access decode; answer one cycle after the request appears
  assign req = avs_read | avs_write;
  assign acc = req & q.ack;
  assign wr_count = acc & avs_write & (avs_address == byte_addr(IDX_COUNT));
  assign wr_period = acc & avs_write & (avs_address == byte_addr(IDX_PERIOD));
  assign wr_ctrl = acc & avs_write & (avs_address == byte_addr(IDX_CTRL));
  assign wr_flag = acc & avs_write & (avs_address == byte_addr(IDX_FLAG));
  assign ctrl_new = merge16(ctrl_word(q.ctrl), avs_writedata, avs_byteenable);

  // Count source selection and gating
  assign mode = mode_of(q.ctrl);
  assign ext_rise = q.ck_s2 & ~q.ck_s3;
  assign gate_fall = q.ck_s3 & ~q.ck_s2;
  assign lim = ps_limit(q.ctrl.prescale_select);
  assign at_period = (q.count_value == q.period_value);
  always_comb begin
    run = q.ctrl.count_enable;
    if (cpu_idle && q.ctrl.idle_stop_bit) begin
      run = 1'b0;
    end
    if (cpu_sleep && (mode != MODE_ASYNC)) begin
      run = 1'b0;
    end
    case (mode)
      MODE_TIMER: src_pulse = 1'b1;
      MODE_GATED: src_pulse = q.ck_s2;
      MODE_SYNC: src_pulse = ext_rise;
      MODE_ASYNC: src_pulse = ext_rise;
      default: src_pulse = 1'b0;
    endcase
  end
  assign in_pulse = run & src_pulse;
  assign tick = in_pulse & (q.presc == lim);
  assign match_set = (tick & at_period) |
                     (q.ctrl.count_enable & (mode == MODE_GATED) & gate_fall);

  // Next state
  always_comb begin
    next_q = q;
    next_q.irq = 1'b0;
    next_q.ck_s1 = external_clock_gate_pin;
    next_q.ck_s2 = q.ck_s1;
    next_q.ck_s3 = q.ck_s2;
    next_q.ack = req & ~q.ack;
    // Prescaler advances only on qualified input pulses
    if (in_pulse) begin
      next_q.presc = (q.presc == lim) ? PS_ZERO : q.presc + PS_ONE;
    end
    // Counter compare and wrap on each prescaled tick
    if (tick) begin
      next_q.count_value = at_period ? COUNT_RST : q.count_value + CNT_ONE;
    end
    if (match_set) begin
      next_q.irq = 1'b1;
    end
    // Read data captured while waitrequest is high
    if (avs_read && !q.ack) begin
      if (avs_address == byte_addr(IDX_COUNT)) begin
        next_q.rdata = {16'h0000, q.count_value};
      end else if (avs_address == byte_addr(IDX_PERIOD)) begin
        next_q.rdata = {16'h0000, q.period_value};
      end else if (avs_address == byte_addr(IDX_CTRL)) begin
        next_q.rdata = {16'h0000, ctrl_word(q.ctrl)};
      end else if (avs_address == byte_addr(IDX_FLAG)) begin
        next_q.rdata = {16'h0000, 15'h0000, q.period_match_flag};
      end else begin
        next_q.rdata = 32'h00000000;
      end
    end
    // Register writes
    if (wr_count) begin
      next_q.count_value = merge16(q.count_value, avs_writedata, avs_byteenable);
      next_q.presc = PS_ZERO;
    end
    if (wr_period) begin
      next_q.period_value = merge16(q.period_value, avs_writedata, avs_byteenable);
    end
    if (wr_ctrl) begin
      next_q.ctrl.count_enable = ctrl_new[CTRL_ON_BIT];
      next_q.ctrl.idle_stop_bit = ctrl_new[CTRL_IDLE_BIT];
      next_q.ctrl.gate_accumulate_enable = ctrl_new[CTRL_GATE_BIT];
      next_q.ctrl.prescale_select = ctrl_new[CTRL_PS_HI:CTRL_PS_LO];
      next_q.ctrl.external_sync_select = ctrl_new[CTRL_SYNC_BIT];
      next_q.ctrl.clock_source_select = ctrl_new[CTRL_CS_BIT];
      if (q.ctrl.count_enable && !ctrl_new[CTRL_ON_BIT]) begin
        next_q.presc = PS_ZERO;
      end
    end
    // Flag: write one to clear, a new match wins
    if (wr_flag && avs_byteenable[0] && avs_writedata[FLAG_BIT]) begin
      next_q.period_match_flag = 1'b0;
    end
    if (match_set) begin
      next_q.period_match_flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.count_value <= COUNT_RST;
      q.period_value <= PERIOD_RST;
      q.presc <= PS_ZERO;
    end else begin
      q <= next_q;
    end
  end

  assign avs_waitrequest = req & ~q.ack;
  assign avs_readdata = q.rdata;
  assign period_match_flag = q.period_match_flag;
  assign irq_request = q.irq;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_match;
    tick && at_period && !wr_count;
  endsequence

  sequence s_flag_raised;
    period_match_flag && irq_request;
  endsequence

  property p_wrap;
    s_match |=> (q.count_value == COUNT_RST);
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap at period");

  property p_incr;
    tick && !at_period && !wr_count |=> q.count_value == $past(q.count_value) + CNT_ONE;
  endproperty
  a_incr: assert property (p_incr) else $error("count did not step by one");

  property p_idle_stop;
    cpu_idle && q.ctrl.idle_stop_bit && !wr_count |=> $stable(q.count_value);
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("count moved in idle");

  property p_ext_count;
    ext_rise && q.ctrl.count_enable && q.ctrl.clock_source_select &&
      (q.ctrl.prescale_select == 2'b00) && !cpu_idle && !cpu_sleep && !at_period && !wr_count
      |=> q.count_value == $past(q.count_value) + CNT_ONE;
  endproperty
  a_ext_count: assert property (p_ext_count) else $error("edge not counted");

  property p_async_idle;
    cpu_idle && !q.ctrl.idle_stop_bit && (mode == MODE_ASYNC) && q.ctrl.count_enable &&
      ext_rise && (q.presc == lim) && !cpu_sleep |-> tick;
  endproperty
  a_async_idle: assert property (p_async_idle) else $error("async stopped in idle");

  property p_sleep_hold;
    cpu_sleep && (mode != MODE_ASYNC) && !wr_count |=> $stable(q.count_value);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

  property p_gate_low;
    (mode == MODE_GATED) && !q.ck_s2 && !wr_count |=> $stable(q.count_value);
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gated count without gate");

  property p_presc_full;
    $changed(q.count_value) && !$past(wr_count) |-> $past(q.presc) == $past(lim);
  endproperty
  a_presc_full: assert property (p_presc_full) else $error("tick before prescale end");

  property p_presc_clr;
    wr_count |=> (q.presc == PS_ZERO);
  endproperty
  a_presc_clr: assert property (p_presc_clr) else $error("prescaler not cleared");

  property p_presc_hold;
    !q.ctrl.count_enable && !wr_count |=> $stable(q.presc);
  endproperty
  a_presc_hold: assert property (p_presc_hold) else $error("idle prescaler changed");

  property p_ctrl_keep;
    wr_ctrl && !tick && !wr_count |=> $stable(q.count_value);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("control write hit count");

  property p_match_irq;
    s_match |=> s_flag_raised;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("no request on match");

  property p_flag_sticky;
    period_match_flag && !wr_flag |=> period_match_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");

  property p_wait_one;
    req && !q.ack |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");

  // Gate fall in gated mode raises flag and request
  property p_gate_irq;
    q.ctrl.count_enable && (mode == MODE_GATED) && gate_fall |=> s_flag_raised;
  endproperty
  a_gate_irq: assert property (p_gate_irq) else $error("no request on gate fall");

  // Write-one clear takes effect when no match competes
  sequence s_flag_clear;
    wr_flag && avs_byteenable[0] && avs_writedata[FLAG_BIT] && !match_set;
  endsequence

  property p_flag_clr;
    s_flag_clear |=> !period_match_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  // Turning the timer off clears the prescaler
  property p_off_clr;
    wr_ctrl && q.ctrl.count_enable && !ctrl_new[CTRL_ON_BIT] |=> (q.presc == PS_ZERO);
  endproperty
  a_off_clr: assert property (p_off_clr) else $error("prescaler kept on disable");

  // A match event always leaves the flag set
  property p_set_wins;
    match_set |=> period_match_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("match lost to clear");

  // Period only changes through its own register write
  property p_period_keep;
    !wr_period |=> $stable(q.period_value);
  endproperty
  a_period_keep: assert property (p_period_keep) else $error("period changed by itself");

  // Async external clock keeps counting through sleep
  property p_sleep_async;
    cpu_sleep && (mode == MODE_ASYNC) && q.ctrl.count_enable && !q.ctrl.idle_stop_bit &&
      ext_rise |-> in_pulse;
  endproperty
  a_sleep_async: assert property (p_sleep_async) else $error("async halted in sleep");

endmodule
`default_nettype wire

// File: test/spt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module spt_pin_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_pulses,
  input wire logic [7:0] half,
  output logic pin,
  output logic busy
);
  initial pin = 1'b0;
  initial busy = 1'b0;
  // Burst of n pulses, pin rests low between bursts
  always @(posedge clk) begin
    if (go) begin
      busy <= 1'b1;
      for (int i = 0; i < n_pulses; i++) begin
        pin <= 1'b1;
        repeat (half) @(posedge clk);
        pin <= 1'b0;
        repeat (half) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top
  import spt_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pin;
  logic busy;
  logic cpu_idle = 1'b0;
  logic cpu_sleep = 1'b0;
  logic period_match_flag;
  logic irq_request;
  logic go = 1'b0;
  logic [7:0] n_pulses = 8'h00;
  logic [7:0] half = 8'h04;
  logic [31:0] rd;
  int failures = 0;
  int tests_run = 0;
  int ratio [4] = '{1, 8, 64, 256};

  // 20 MHz clock
  always #25 clk = ~clk;

  spt_timer i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .external_clock_gate_pin(pin), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .period_match_flag(period_match_flag), .irq_request(irq_request));

  spt_pin_model i_pin (.clk(clk), .go(go), .n_pulses(n_pulses), .half(half), .pin(pin),
    .busy(busy));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bounded wait hit its limit
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      failures++;
      give_verdict();
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic wait_ack();
    int n;
    n = 0;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    tmo(n, 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic bus_wr(input logic [15:0] idx, input logic [15:0] d);
    @(posedge clk);
    avs_address <= ADDR_W'({idx, 2'b00});
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    wait_ack();
  endtask

  task automatic bus_rd(input logic [15:0] idx);
    @(posedge clk);
    avs_address <= ADDR_W'({idx, 2'b00});
    avs_read <= 1'b1;
    wait_ack();
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [15:0] e, input string nm);
    bus_rd(idx);
    `CHK(nm, {16'h0000, e}, rd)
  endtask

  // Cycles between two match pulses
  task automatic gap_chk(input int e);
    int n;
    n = 0;
    @(negedge clk);
    while (irq_request !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    tmo(n, 3000);
    n = 0;
    @(negedge clk);
    n++;
    while (irq_request !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    `CHK("match_gap", e, n)
  endtask

  task automatic pulses(input logic [7:0] n, input logic [7:0] h);
    int k;
    k = 0;
    @(posedge clk);
    n_pulses <= n;
    half <= h;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    while (busy !== 1'b0 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    tmo(k, 3000);
    repeat (6) @(posedge clk);
  endtask

  // External count from zero, then read back
  task automatic ext_cnt(input logic [15:0] ctl, input logic [15:0] e, input string nm);
    bus_wr(IDX_CTRL, ctl);
    bus_wr(IDX_COUNT, 16'h0000);
    pulses(8'h05, 8'h04);
    rd_chk(IDX_COUNT, e, nm);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(IDX_COUNT, 16'h0000, "count_rst");
    rd_chk(IDX_PERIOD, 16'hFFFF, "period_rst");
    rd_chk(IDX_CTRL, 16'h0000, "ctrl_rst");
    rd_chk(16'h0110, 16'h0000, "unmapped");
    // Timer mode, every prescale ratio
    bus_wr(IDX_PERIOD, 16'h0003);
    for (int ps = 0; ps < 4; ps++) begin
      bus_wr(IDX_CTRL, {8'h80, 2'b00, 2'(ps), 4'h0});
      gap_chk(4 * ratio[ps]);
    end
    bus_wr(IDX_CTRL, 16'h0000);
    rd_chk(IDX_FLAG, 16'h0001, "flag_sticky");
    bus_wr(IDX_FLAG, 16'h0001);
    rd_chk(IDX_FLAG, 16'h0000, "flag_clear");
    bus_wr(IDX_PERIOD, 16'hFFFF);
    bus_wr(IDX_COUNT, 16'h1234);
    bus_wr(IDX_CTRL, 16'h0074);
    rd_chk(IDX_COUNT, 16'h1234, "count_ctrl_wr");
    rd_chk(IDX_CTRL, 16'h0074, "ctrl_rb");
    // Idle with and without the stop bit
    cpu_idle <= 1'b1;
    bus_wr(IDX_CTRL, 16'hA000);
    rd_chk(IDX_COUNT, 16'h1234, "idle_stop");
    bus_wr(IDX_CTRL, 16'h8000);
    bus_wr(IDX_CTRL, 16'hA000);
    bus_rd(IDX_COUNT);
    `CHK("idle_run", 1'b1, rd[15:0] != 16'h1234)
    rd_chk(IDX_COUNT, rd[15:0], "idle_frozen");
    // Sleep stops timer mode, async external keeps counting
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b1;
    bus_wr(IDX_CTRL, 16'h8000);
    bus_wr(IDX_COUNT, 16'h0000);
    rd_chk(IDX_COUNT, 16'h0000, "sleep_timer");
    ext_cnt(16'h8006, 16'h0000, "sleep_sync");
    ext_cnt(16'h8002, 16'h0005, "sleep_async");
    cpu_sleep <= 1'b0;
    ext_cnt(16'h8006, 16'h0005, "sync_cnt");
    cpu_idle <= 1'b1;
    ext_cnt(16'hA002, 16'h0000, "async_idle_stop");
    ext_cnt(16'h8002, 16'h0005, "async_idle_run");
    cpu_idle <= 1'b0;
    // Gated accumulation, one 10-cycle gate
    bus_wr(IDX_CTRL, 16'h8040);
    bus_wr(IDX_COUNT, 16'h0000);
    bus_wr(IDX_FLAG, 16'h0001);
    pulses(8'h01, 8'h0A);
    rd_chk(IDX_COUNT, 16'h000A, "gated_cnt");
    rd_chk(IDX_FLAG, 16'h0001, "gate_fall");
    give_verdict();
  end
endmodule
`default_nettype wire
